// ### rtl/sdm_pkg.sv
// Shared constants, types and field layouts of the SDRAM front end
package sdm_pkg;
    localparam int ADDR_W      = 13;
    localparam int COL_W       = 9;
    localparam int NUM_BANKS   = 4;

    // Operating-mode word fields
    localparam int OM_BL_LSB   = 0;
    localparam int OM_BT_BIT   = 3;
    localparam int OM_LAT_LSB  = 4;
    localparam int OM_WBM_BIT  = 9;
    localparam logic [ADDR_W-1:0] OM_RESET = 13'h0000;

    // Low-power mode word fields
    localparam int LP_PRS_LSB  = 0;
    localparam int LP_TRS_LSB  = 3;
    localparam logic [ADDR_W-1:0] LP_RESET = 13'h0000;

    // Field codes
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] LAT_2   = 3'h2;
    localparam logic [2:0] LAT_3   = 3'h3;
    localparam logic [1:0] TRS_SENSOR = 2'h0;
    localparam logic [1:0] BANKSEL_OPMODE = 2'h0;
    localparam logic [1:0] BANKSEL_LPMODE = 2'h2;

    // Command code on {row strobe, column strobe, write enable}, all low active
    localparam logic [2:0] CODE_ACT  = 3'h3;
    localparam logic [2:0] CODE_RD   = 3'h5;
    localparam logic [2:0] CODE_WR   = 3'h4;
    localparam logic [2:0] CODE_BST  = 3'h6;
    localparam logic [2:0] CODE_PRE  = 3'h2;
    localparam logic [2:0] CODE_REF  = 3'h1;
    localparam logic [2:0] CODE_LOAD = 3'h0;
    localparam int PRECH_ALL_BIT = 10;

    // Initialization
    localparam logic [3:0] MIN_REFRESHES = 4'h8;

    // Pin group sampled on each rising edge
    typedef struct packed {
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              bank_select_high;
        logic              bank_select_low;
        logic [ADDR_W-1:0] addr;
    } sdm_cmd_t;

    // One column beat of a burst
    typedef struct packed {
        logic              valid;
        logic [1:0]        bank;
        logic [ADDR_W-1:0] row;
        logic [COL_W-1:0]  col;
    } sdm_beat_t;

    typedef enum logic [2:0] {
        INIT_POWERUP,
        INIT_PRECHARGED,
        INIT_REFRESHED,
        INIT_READY
    } sdm_init_t;
endpackage

// ### rtl/sdm_front.sv
// SDRAM front end: command decode, mode words, burst column sequencing, read latency
`timescale 1ns/10ps
`default_nettype none
module sdm_front (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset_n,
    // Command, bank and address pins
    input  wire sdm_pkg::sdm_cmd_t         cmd_pins,
    // Column beats toward the array
    output sdm_pkg::sdm_beat_t             write_beat,
    output sdm_pkg::sdm_beat_t             read_beat,
    // Mode words, decoded low-power settings and initialization status
    output logic [sdm_pkg::ADDR_W-1:0]     operating_mode_word,
    output logic [sdm_pkg::ADDR_W-1:0]     low_power_mode_word,
    output logic [3:0]                     refresh_bank_mask,
    output logic [1:0]                     refresh_bank_fraction,
    output logic                           temp_sensor_enable,
    output logic                           init_ready
);
    import sdm_pkg::*;

    sdm_cmd_t           sync1_ff;
    sdm_cmd_t           cmd;
    logic [ADDR_W-1:0]  om_ff;
    logic [ADDR_W-1:0]  lp_ff;
    logic [ADDR_W-1:0]  row_ff [NUM_BANKS];
    logic               burst_on_ff;
    logic               burst_wr_ff;
    logic [COL_W-1:0]   start_ff;
    logic [COL_W-1:0]   cnt_ff;
    logic [COL_W-1:0]   mask_ff;
    logic               full_ff;
    logic               itl_ff;
    logic [1:0]         bank_ff;
    sdm_beat_t          beat_ff;
    logic               beat_wr_ff;
    sdm_beat_t          rd_pipe_ff [2];
    sdm_init_t          init_ff;
    sdm_init_t          nxt_init;
    logic [3:0]         ref_cnt_ff;
    logic               om_loaded_ff;
    logic               lp_loaded_ff;

    // Burst length code to in-block offset mask; reserved codes act as length one
    function automatic logic [COL_W-1:0] len_mask(input logic [2:0] code);
        unique case (code)
            BL_2:    len_mask = 9'h001;
            BL_4:    len_mask = 9'h003;
            BL_8:    len_mask = 9'h007;
            BL_PAGE: len_mask = 9'h1ff;
            default: len_mask = 9'h000;
        endcase
    endfunction

    // Pins cross in through two stages
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_ff <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            cmd      <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
        end
        else
        begin
            sync1_ff <= cmd_pins;
            cmd      <= sync1_ff;
        end
    end

    // Command decode
    wire       selected  = cmd.cke && !cmd.cs_n;
    wire [2:0] code      = {cmd.ras_n, cmd.cas_n, cmd.we_n};
    wire [1:0] banksel   = {cmd.bank_select_high, cmd.bank_select_low};
    wire       cmd_act   = selected && code == CODE_ACT;
    wire       cmd_rd    = selected && code == CODE_RD;
    wire       cmd_wr    = selected && code == CODE_WR;
    wire       cmd_bst   = selected && code == CODE_BST;
    wire       cmd_pre   = selected && code == CODE_PRE;
    wire       cmd_ref   = selected && code == CODE_REF;
    wire       cmd_load  = selected && code == CODE_LOAD;
    wire       load_om   = cmd_load && banksel == BANKSEL_OPMODE;
    wire       load_lp   = cmd_load && banksel == BANKSEL_LPMODE;
    wire       start_cmd = cmd_rd || cmd_wr;

    // Operating word fields
    wire [2:0] bl_code   = om_ff[OM_BL_LSB +: 3];
    wire       om_itl    = om_ff[OM_BT_BIT];
    wire [2:0] lat_code  = om_ff[OM_LAT_LSB +: 3];
    wire       om_wbm    = om_ff[OM_WBM_BIT];
    wire       is_page   = bl_code == BL_PAGE;
    wire       lat_two   = lat_code == LAT_2;

    // Mode words hold until reloaded; other bank codes are ignored
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            om_ff <= OM_RESET;
            lp_ff <= LP_RESET;
        end
        else
        begin
            if (load_om)
                om_ff <= cmd.addr;
            if (load_lp)
                lp_ff <= cmd.addr;
        end
    end

    // Open row per bank
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int b = 0; b < NUM_BANKS; b++)
                row_ff[b] <= '0;
        end
        else if (cmd_act)
            row_ff[banksel] <= cmd.addr;
    end

    // Burst parameters for the current beat
    wire [COL_W-1:0] new_mask  = (cmd_wr && om_wbm) ? 9'h000 : len_mask(bl_code);
    wire [COL_W-1:0] cur_start = start_cmd ? cmd.addr[COL_W-1:0] : start_ff;
    wire [COL_W-1:0] cur_cnt   = start_cmd ? 9'h000 : cnt_ff;
    wire [COL_W-1:0] cur_mask  = start_cmd ? new_mask : mask_ff;
    wire             cur_full  = start_cmd ? (is_page && !(cmd_wr && om_wbm)) : full_ff;
    // Full page has no interleaved order, so it always runs sequentially
    wire             cur_itl   = start_cmd ? (om_itl && !is_page) : itl_ff;
    wire [COL_W-1:0] seq_off   = COL_W'(cur_start + cur_cnt);
    wire [COL_W-1:0] itl_off   = cur_start ^ cur_cnt;
    wire [COL_W-1:0] beat_col  = (cur_start & ~cur_mask)
                                 | ((cur_itl ? itl_off : seq_off) & cur_mask);
    wire             beat_go   = start_cmd || (burst_on_ff && !cmd_bst && !cmd_pre);
    wire             beat_last = !cur_full && cur_cnt == cur_mask;
    wire [1:0]       cur_bank  = start_cmd ? banksel : bank_ff;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            burst_on_ff <= 1'b0;
            burst_wr_ff <= 1'b0;
            start_ff    <= '0;
            cnt_ff      <= '0;
            mask_ff     <= '0;
            full_ff     <= 1'b0;
            itl_ff      <= 1'b0;
            bank_ff     <= '0;
        end
        else
        begin
            burst_on_ff <= beat_go && !beat_last;
            cnt_ff      <= COL_W'(cur_cnt + 9'h001);
            if (start_cmd)
            begin
                burst_wr_ff <= cmd_wr;
                start_ff    <= cmd.addr[COL_W-1:0];
                mask_ff     <= new_mask;
                full_ff     <= cur_full;
                itl_ff      <= cur_itl;
                bank_ff     <= banksel;
            end
        end
    end

    // Beat register and read latency pipeline
    wire sdm_beat_t nxt_beat = '{valid: beat_go, bank: cur_bank, row: row_ff[cur_bank], col: beat_col};
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            beat_ff       <= '0;
            beat_wr_ff    <= 1'b0;
            rd_pipe_ff[0] <= '0;
            rd_pipe_ff[1] <= '0;
        end
        else
        begin
            beat_ff       <= nxt_beat;
            beat_wr_ff    <= start_cmd ? cmd_wr : burst_wr_ff;
            rd_pipe_ff[0] <= (beat_ff.valid && !beat_wr_ff) ? beat_ff : '0;
            rd_pipe_ff[1] <= rd_pipe_ff[0];
        end
    end

    assign write_beat = (beat_ff.valid && beat_wr_ff) ? beat_ff : '0;
    // Reserved latency codes behave as three
    assign read_beat  = lat_two ? rd_pipe_ff[0] : rd_pipe_ff[1];

    // Initialization progress
    always_comb
    begin
        nxt_init = init_ff;
        unique case (init_ff)
            INIT_POWERUP:
                if (cmd_pre && cmd.addr[PRECH_ALL_BIT])
                    nxt_init = INIT_PRECHARGED;
            INIT_PRECHARGED:
                if (cmd_ref && ref_cnt_ff == MIN_REFRESHES - 4'h1)
                    nxt_init = INIT_REFRESHED;
            INIT_REFRESHED:
                if ((om_loaded_ff || load_om) && (lp_loaded_ff || load_lp))
                    nxt_init = INIT_READY;
            INIT_READY:
                nxt_init = INIT_READY;
            default:
                nxt_init = INIT_POWERUP;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            init_ff      <= INIT_POWERUP;
            ref_cnt_ff   <= '0;
            om_loaded_ff <= 1'b0;
            lp_loaded_ff <= 1'b0;
        end
        else
        begin
            init_ff      <= nxt_init;
            ref_cnt_ff   <= (cmd_ref && init_ff == INIT_PRECHARGED) ? ref_cnt_ff + 4'h1 : ref_cnt_ff;
            om_loaded_ff <= om_loaded_ff || (load_om && init_ff == INIT_REFRESHED);
            lp_loaded_ff <= lp_loaded_ff || (load_lp && init_ff == INIT_REFRESHED);
        end
    end

    assign init_ready = init_ff == INIT_READY;

    // Low-power settings
    wire [2:0] prs = lp_ff[LP_PRS_LSB +: 3];
    assign refresh_bank_mask     = prs == 3'h0 ? 4'hf : (prs == 3'h1 ? 4'h3 : 4'h1);
    // Fraction of the kept bank: 0 whole, 1 half, 2 quarter
    assign refresh_bank_fraction = prs == 3'h5 ? 2'h1 : (prs == 3'h6 ? 2'h2 : 2'h0);
    assign temp_sensor_enable    = lp_ff[LP_TRS_LSB +: 2] == TRS_SENSOR;
    assign operating_mode_word   = om_ff;
    assign low_power_mode_word   = lp_ff;

    // Checks
    sequence s_rd_cmd_lat2;
        cmd_rd && lat_two;
    endsequence
    sequence s_rd_first_beat;
        read_beat.valid && read_beat.col == $past(cmd.addr[COL_W-1:0], 2);
    endsequence

    property p_om_load;
        @(posedge sys_clk) disable iff (!reset_n) load_om |=> om_ff == $past(cmd.addr);
    endproperty
    a_om_load: assert property (p_om_load) else $error("operating word not loaded");

    property p_lp_load;
        @(posedge sys_clk) disable iff (!reset_n) load_lp |=> lp_ff == $past(cmd.addr) && $stable(om_ff);
    endproperty
    a_lp_load: assert property (p_lp_load) else $error("low-power word not loaded");

    property p_words_hold;
        @(posedge sys_clk) disable iff (!reset_n) !load_om && !load_lp |=> $stable(om_ff) && $stable(lp_ff);
    endproperty
    a_words_hold: assert property (p_words_hold) else $error("mode word changed without load");

    property p_first_col;
        @(posedge sys_clk) disable iff (!reset_n)
            start_cmd |=> beat_ff.valid && beat_ff.col == $past(cmd.addr[COL_W-1:0]);
    endproperty
    a_first_col: assert property (p_first_col) else $error("burst did not start at column");

    property p_lat2;
        @(posedge sys_clk) disable iff (!reset_n) s_rd_cmd_lat2 |-> ##2 s_rd_first_beat;
    endproperty
    a_lat2: assert property (p_lat2) else $error("read data not at latency two");

    property p_lat3;
        @(posedge sys_clk) disable iff (!reset_n)
            cmd_rd && lat_code == LAT_3 |-> ##2 !read_beat.valid ##1 read_beat.valid;
    endproperty
    a_lat3: assert property (p_lat3) else $error("read data not at latency three");

    property p_single_write;
        @(posedge sys_clk) disable iff (!reset_n) cmd_wr && om_wbm |=> !burst_on_ff && write_beat.valid;
    endproperty
    a_single_write: assert property (p_single_write) else $error("single write ran on");

    property p_in_block;
        @(posedge sys_clk) disable iff (!reset_n)
            burst_on_ff && !start_cmd && !cmd_bst && !cmd_pre
            |=> ((beat_ff.col ^ $past(start_ff)) & ~$past(mask_ff)) == 9'h000;
    endproperty
    a_in_block: assert property (p_in_block) else $error("beat left its column block");

    property p_page_runs;
        @(posedge sys_clk) disable iff (!reset_n)
            burst_on_ff && full_ff && !start_cmd && !cmd_bst && !cmd_pre |=> burst_on_ff;
    endproperty
    a_page_runs: assert property (p_page_runs) else $error("full page burst ended itself");

    property p_bst_stops;
        @(posedge sys_clk) disable iff (!reset_n) cmd_bst |=> !burst_on_ff && !beat_ff.valid;
    endproperty
    a_bst_stops: assert property (p_bst_stops) else $error("burst kept running after stop");
endmodule
`default_nettype wire

// ### tb/sdm_ctrl_model.sv
// Memory controller model that drives the command pins of the SDRAM front end
`timescale 1ns/10ps
`default_nettype none
module sdm_ctrl_model #(
    parameter int POWERUP_CYCLES = 8000
) (
    // Clock
    input  wire logic                 sys_clk,
    // Command pins toward the device
    output var sdm_pkg::sdm_cmd_t     cmd_pins
);
    import sdm_pkg::*;

    // Idle: deselected, clock gate high
    initial cmd_pins = {1'b1, 1'b1, 3'h7, 2'h0, 13'h0000};

    // One command for one edge, then deselect with the address lines inverted
    task automatic send(input logic sel, input logic [2:0] code, input logic [1:0] bank,
                        input logic [ADDR_W-1:0] addr);
        @(posedge sys_clk);
        cmd_pins <= {1'b1, ~sel, code, bank, addr};
        @(posedge sys_clk);
        cmd_pins <= {1'b1, 1'b1, 3'h7, ~bank, ~addr};
    endtask

    // Close all banks before a mode load
    task automatic load(input logic [1:0] bank, input logic [ADDR_W-1:0] word);
        send(1'b1, CODE_PRE, 2'h0, 13'h0400);
        send(1'b1, CODE_LOAD, bank, word);
    endtask

    // Power-up wait, precharge all, refreshes, operating word; low-power load left to caller
    task automatic init(input logic [ADDR_W-1:0] om);
        repeat (POWERUP_CYCLES) @(posedge sys_clk);
        send(1'b1, CODE_PRE, 2'h0, 13'h0400);
        repeat (MIN_REFRESHES) send(1'b1, CODE_REF, 2'h0, 13'h0000);
        send(1'b1, CODE_LOAD, BANKSEL_OPMODE, om);
    endtask
endmodule
`default_nettype wire

// ### tb/tb_sdm_front.sv
// Self-checking bench of the SDRAM front end
`timescale 1ns/10ps
`default_nettype none
module tb_sdm_front;
    import sdm_pkg::*;
    logic               sys_clk;
    logic               reset_n;
    sdm_cmd_t           cmd_pins;
    sdm_beat_t          write_beat;
    sdm_beat_t          read_beat;
    logic [ADDR_W-1:0]  operating_mode_word;
    logic [ADDR_W-1:0]  low_power_mode_word;
    logic [3:0]         refresh_bank_mask;
    logic [1:0]         refresh_bank_fraction;
    logic               temp_sensor_enable;
    logic               init_ready;
    int                 num_errors;
    int                 num_checks;

    sdm_ctrl_model sdm_ctrl_model_inst (.sys_clk(sys_clk), .cmd_pins(cmd_pins));

    sdm_front sdm_front_inst (
        .sys_clk               (sys_clk),
        .reset_n               (reset_n),
        .cmd_pins              (cmd_pins),
        .write_beat            (write_beat),
        .read_beat             (read_beat),
        .operating_mode_word   (operating_mode_word),
        .low_power_mode_word   (low_power_mode_word),
        .refresh_bank_mask     (refresh_bank_mask),
        .refresh_bank_fraction (refresh_bank_fraction),
        .temp_sensor_enable    (temp_sensor_enable),
        .init_ready            (init_ready)
    );

    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Settle just after the n-th coming edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [ADDR_W-1:0] om_of(input logic wbm, input logic [2:0] lat, input logic bt,
                                                 input logic [2:0] bl);
        return {3'h0, wbm, 2'h0, lat, bt, bl};
    endfunction

    task automatic t_reset();
        tick(15);
        chk(write_beat, 25'h0);
        chk(read_beat, 25'h0);
        chk({operating_mode_word, low_power_mode_word}, {OM_RESET, LP_RESET});
        chk({refresh_bank_mask, refresh_bank_fraction, temp_sensor_enable, init_ready}, 8'hf2);
    endtask

    task automatic t_init();
        sdm_ctrl_model_inst.init(om_of(1'b0, LAT_2, 1'b0, BL_4));
        tick(3);
        chk(init_ready, 1'b0);
        chk(operating_mode_word, 13'h0022);
        sdm_ctrl_model_inst.send(1'b1, CODE_LOAD, BANKSEL_LPMODE, 13'h0000);
        tick(3);
        chk(init_ready, 1'b1);
    endtask

    // Activate, then one access; beats judged at their exact edges
    task automatic t_burst(input logic wr, input logic [ADDR_W-1:0] om, input logic [8:0] start, input int blk);
        logic [8:0]  mask;
        logic [8:0]  col;
        logic [1:0]  bank;
        sdm_beat_t   b;
        int          cnt;
        mask = 9'(blk - 1);
        bank = start[1:0] ^ 2'h2;
        cnt  = (blk > 8) ? 6 : blk;
        sdm_ctrl_model_inst.load(BANKSEL_OPMODE, om);
        sdm_ctrl_model_inst.send(1'b1, CODE_ACT, bank, {4'h5, start});
        sdm_ctrl_model_inst.send(1'b1, wr ? CODE_WR : CODE_RD, bank, {4'h0, start});
        tick(wr ? 2 : ((om[6:4] == LAT_2) ? 3 : 4));
        for (int k = 0; k < cnt; k++)
        begin
            b   = wr ? write_beat : read_beat;
            col = om[OM_BT_BIT] ? ((start & ~mask) | ((start ^ 9'(k)) & mask))
                                : ((start & ~mask) | ((start + 9'(k)) & mask));
            chk(b, {1'b1, bank, 4'h5, start, col});
            tick(1);
        end
        if (blk > 8)
        begin
            sdm_ctrl_model_inst.send(1'b1, CODE_BST, 2'h0, 13'h0000);
            tick(6);
        end
        chk(wr ? write_beat.valid : read_beat.valid, 1'b0);
        chk(operating_mode_word, om);
    endtask

    task automatic t_bursts();
        t_burst(1'b0, om_of(1'b0, LAT_2, 1'b0, BL_4), 9'h005, 4);
        t_burst(1'b0, om_of(1'b0, LAT_3, 1'b1, BL_8), 9'h00d, 8);
        t_burst(1'b1, om_of(1'b0, LAT_2, 1'b0, BL_2), 9'h003, 2);
        t_burst(1'b0, om_of(1'b0, LAT_3, 1'b0, BL_1), 9'h01a, 1);
        t_burst(1'b1, om_of(1'b1, LAT_2, 1'b1, BL_8), 9'h0a6, 1);
        t_burst(1'b1, om_of(1'b0, LAT_2, 1'b0, BL_8), 9'h0a6, 8);
        t_burst(1'b0, om_of(1'b0, LAT_2, 1'b1, BL_2), 9'h101, 2);
        t_burst(1'b0, om_of(1'b0, LAT_2, 1'b0, BL_PAGE), 9'h1fe, 512);
    endtask

    task automatic t_lowpower();
        logic [2:0] prs [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
        logic [1:0] trs;
        for (int i = 0; i < 5; i++)
        begin
            trs = 2'(3 - (i % 4));
            sdm_ctrl_model_inst.load(BANKSEL_LPMODE, {8'h00, trs, prs[i]});
            tick(3);
            chk(low_power_mode_word, {8'h00, trs, prs[i]});
            chk(refresh_bank_mask, (prs[i] == 3'h0) ? 4'hf : ((prs[i] == 3'h1) ? 4'h3 : 4'h1));
            chk(refresh_bank_fraction, (prs[i] == 3'h5) ? 2'h1 : ((prs[i] == 3'h6) ? 2'h2 : 2'h0));
            chk(temp_sensor_enable, trs == TRS_SENSOR);
        end
        chk(operating_mode_word, 13'h0027);
    endtask

    // Reserved bank codes and a deselected load leave both words alone
    task automatic t_refused();
        sdm_ctrl_model_inst.send(1'b1, CODE_LOAD, 2'h1, 13'h1fff);
        sdm_ctrl_model_inst.send(1'b1, CODE_LOAD, 2'h3, 13'h1fff);
        sdm_ctrl_model_inst.send(1'b0, CODE_LOAD, BANKSEL_OPMODE, 13'h1fff);
        tick(3);
        chk(operating_mode_word, 13'h0027);
        chk(low_power_mode_word, 13'h001e);
    endtask

    initial
    begin
        num_errors = 0;
        num_checks = 0;
        reset_n    = 1'b0;
        t_reset();
        @(posedge sys_clk);
        reset_n <= 1'b1;
        t_init();
        t_bursts();
        t_lowpower();
        t_refused();
        stop_test();
    end

    // Hang guard
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
